// file: wpt_pkg.sv
package wpt_pkg;

   // Trigger modes
   typedef enum logic [2:0] {
      MODE_AUTO          = 3'h0,
      MODE_RETRIGGER     = 3'h1,
      MODE_ARMED_AUTO    = 3'h2,
      MODE_ARMED_RETRIG  = 3'h3,
      MODE_SINGLE        = 3'h4
   } wpt_mode_t;

   // Duration unit for single-shot mode
   typedef enum logic {
      UNIT_SAMPLE   = 1'b0,
      UNIT_SEQUENCE = 1'b1
   } wpt_unit_t;

   localparam int DUR_W = 32;
   localparam int LEN_W = 24;
   localparam logic [DUR_W-1:0] DUR_ZERO = 32'h0000_0000;
   localparam logic [LEN_W-1:0] LEN_ZERO = 24'h00_0000;
   localparam logic [LEN_W-1:0] LEN_ONE  = 24'h00_0001;
   localparam logic [DUR_W-1:0] DUR_ONE  = 32'h0000_0001;

   // Static configuration from control software
   typedef struct packed {
      logic               enable;
      wpt_mode_t          mode;
      logic               srcExternal;
      logic               extRising;
      wpt_unit_t          durUnit;
      logic [DUR_W-1:0]   duration;
      logic [LEN_W-1:0]   waveLength;
   } wpt_cfg_t;

   // One-cycle commands
   typedef struct packed {
      logic arm;
      logic manualTrig;
   } wpt_cmd_t;

   // Playback steering towards the sample reader
   typedef struct packed {
      logic               play;
      logic               restart;
      logic [LEN_W-1:0]   sampleAddr;
   } wpt_play_t;

endpackage

// file: wpt_trigger_ctrl.sv
`timescale 1ns/1ps
module wpt_trigger_ctrl (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              sys_rst,
   // Control software
   input  wire wpt_pkg::wpt_cfg_t cfg,
   input  wire wpt_pkg::wpt_cmd_t cmd,
   // External trigger pin
   input  wire logic              extTrigIn,
   // Playback and status
   output wpt_pkg::wpt_play_t     playOut,
   output logic                   running,
   output logic                   stopped,
   output logic                   trigEvent
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_PLAY = 2'b11,
      ST_DONE = 2'b10
   } wpt_state_t;

   // External trigger synchroniser and edge detect
   logic       extSync1_q;
   logic       extSync1_d;
   logic       extSync2_q;
   logic       extSync2_d;
   logic       extPrev_q;
   logic       extPrev_d;
   logic [2:0] fill_q;
   logic [2:0] fill_d;
   logic       extEdge;
   logic       intEvent;
   logic       event_w;

   // Active edge of the synchronised pin for the chosen polarity
   function automatic logic edgeOf(
      input logic cur,
      input logic prev,
      input logic rising
   );
      logic r;
      r = 1'b0;
      if (rising) begin
         r = cur & ~prev;
      end else begin
         r = ~cur & prev;
      end
      return r;
   endfunction

   // Only the second stage reads the first stage
   always_comb begin
      extSync1_d = extTrigIn;
      extSync2_d = extSync1_q;
      extPrev_d  = extSync2_q;
      fill_d     = {fill_q[1:0], 1'b1};
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         extSync1_q <= 1'b0;
         extSync2_q <= 1'b0;
         extPrev_q  <= 1'b0;
         fill_q     <= 3'h0;
      end else begin
         extSync1_q <= extSync1_d;
         extSync2_q <= extSync2_d;
         extPrev_q  <= extPrev_d;
         fill_q     <= fill_d;
      end
   end

   // No edge until the history holds a real pin sample, so a pin that
   // idles high cannot fake an edge just after reset
   always_comb begin
      extEdge  = fill_q[2] &
                 edgeOf(extSync2_q, extPrev_q, cfg.extRising);
      intEvent = cmd.manualTrig & ~cfg.srcExternal;
      event_w  = cfg.srcExternal ? extEdge : intEvent;
   end

   // Sequencer state
   wpt_state_t               state_q;
   wpt_state_t               state_d;
   logic [wpt_pkg::LEN_W-1:0] addr_q;
   logic [wpt_pkg::LEN_W-1:0] addr_d;
   logic [wpt_pkg::DUR_W-1:0] left_q;
   logic [wpt_pkg::DUR_W-1:0] left_d;
   logic                      restart_q;
   logic                      restart_d;
   logic                      running_q;
   logic                      running_d;
   logic                      stopped_q;
   logic                      stopped_d;
   logic                      trig_q;
   logic                      trig_d;
   logic                      armedMode;
   logic                      startPass;
   logic                      lastSample;
   logic                      freeRunMode;
   logic                      zeroPass;
   logic                      loadLeft;
   logic                      stepLeft;
   logic [wpt_pkg::DUR_W-1:0] passLenNow;

   // Modes that play without waiting for any event
   function automatic logic isFreeRun(
      input wpt_pkg::wpt_mode_t m
   );
      return (m == wpt_pkg::MODE_AUTO) || (m == wpt_pkg::MODE_RETRIGGER);
   endfunction

   // Modes where an arm command stops playback
   function automatic logic isArmed(
      input wpt_pkg::wpt_mode_t m
   );
      return (m == wpt_pkg::MODE_ARMED_AUTO) ||
             (m == wpt_pkg::MODE_ARMED_RETRIG);
   endfunction

   // Modes where an event during playback restarts the waveform
   function automatic logic restartsOnEvent(
      input wpt_pkg::wpt_mode_t m
   );
      return (m != wpt_pkg::MODE_AUTO) && (m != wpt_pkg::MODE_ARMED_AUTO);
   endfunction

   // Next sample address, wrapping at the waveform end
   function automatic logic [wpt_pkg::LEN_W-1:0] nextAddr(
      input logic [wpt_pkg::LEN_W-1:0] a,
      input logic [wpt_pkg::LEN_W-1:0] len
   );
      logic [wpt_pkg::LEN_W-1:0] r;
      r = wpt_pkg::LEN_ZERO;
      if ((len == wpt_pkg::LEN_ZERO) || (a >= len - wpt_pkg::LEN_ONE)) begin
         r = wpt_pkg::LEN_ZERO;
      end else begin
         r = a + wpt_pkg::LEN_ONE;
      end
      return r;
   endfunction

   // Single-shot length in samples
   function automatic logic [wpt_pkg::DUR_W-1:0] passLen(
      input wpt_pkg::wpt_cfg_t c
   );
      logic [wpt_pkg::DUR_W-1:0] r;
      logic [2*wpt_pkg::DUR_W-1:0] prod;
      r    = wpt_pkg::DUR_ZERO;
      prod = {wpt_pkg::DUR_ZERO, wpt_pkg::DUR_ZERO};
      if (c.durUnit == wpt_pkg::UNIT_SEQUENCE) begin
         prod = c.duration * {{(wpt_pkg::DUR_W-wpt_pkg::LEN_W){1'b0}},
                              c.waveLength};
         r    = prod[wpt_pkg::DUR_W-1:0];
      end else begin
         r = c.duration;
      end
      return r;
   endfunction

   always_comb begin
      state_d     = state_q;
      addr_d      = addr_q;
      loadLeft    = 1'b0;
      stepLeft    = 1'b0;
      restart_d   = 1'b0;
      armedMode   = isArmed(cfg.mode);
      freeRunMode = isFreeRun(cfg.mode);
      passLenNow  = passLen(cfg);
      zeroPass    = (passLenNow == wpt_pkg::DUR_ZERO);
      startPass   = 1'b0;
      lastSample  = (left_q == wpt_pkg::DUR_ONE);

      if (!cfg.enable) begin
         state_d = ST_IDLE;
         addr_d  = wpt_pkg::LEN_ZERO;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (freeRunMode) begin
                  state_d   = ST_PLAY;
                  restart_d = 1'b1;
                  addr_d    = wpt_pkg::LEN_ZERO;
               end else begin
                  state_d = ST_WAIT;
               end
            end
            ST_WAIT, ST_DONE: begin
               if (event_w) begin
                  startPass = 1'b1;
               end
            end
            ST_PLAY: begin
               if (armedMode && cmd.arm) begin
                  state_d = ST_WAIT;
                  addr_d  = wpt_pkg::LEN_ZERO;
               end else if (event_w && restartsOnEvent(cfg.mode)) begin
                  startPass = 1'b1;
                  // Armed-retrigger restarts with no arm needed
                  // Single restarts a fresh pass
               end else if (cfg.mode == wpt_pkg::MODE_SINGLE &&
                            lastSample) begin
                  state_d = ST_DONE;
                  addr_d  = wpt_pkg::LEN_ZERO;
               end else begin
                  addr_d = nextAddr(addr_q, cfg.waveLength);
                  if (cfg.mode == wpt_pkg::MODE_SINGLE) begin
                     stepLeft = 1'b1;
                  end
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
         // Mode change to a free-run mode resumes playback
         if ((state_q == ST_WAIT || state_q == ST_DONE) && freeRunMode) begin
            state_d = ST_IDLE;
         end
      end

      if (startPass) begin
         // Zero-length single pass plays nothing and goes to ST_DONE
         if (cfg.mode == wpt_pkg::MODE_SINGLE && zeroPass) begin
            state_d = ST_DONE;
         end else begin
            state_d   = ST_PLAY;
            restart_d = 1'b1;
            addr_d    = wpt_pkg::LEN_ZERO;
            loadLeft  = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q   <= ST_IDLE;
         addr_q    <= wpt_pkg::LEN_ZERO;
         restart_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         addr_q    <= addr_d;
         restart_q <= restart_d;
      end
   end

   // Single-shot sample budget, loaded at pass start
   always_comb begin
      left_d = left_q;
      if (loadLeft) begin
         left_d = passLenNow;
      end else if (stepLeft) begin
         left_d = left_q - wpt_pkg::DUR_ONE;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         left_q <= wpt_pkg::DUR_ZERO;
      end else begin
         left_q <= left_d;
      end
   end

   // Run and stop flags follow the state that is being entered; trigEvent follows the event
   always_comb begin
      trig_d    = event_w;
      running_d = (state_d == ST_PLAY);
      stopped_d = cfg.enable && (state_d != ST_PLAY);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         running_q <= 1'b0;
         stopped_q <= 1'b0;
         trig_q    <= 1'b0;
      end else begin
         running_q <= running_d;
         stopped_q <= stopped_d;
         trig_q    <= trig_d;
      end
   end

   assign playOut.play       = running_q;
   assign playOut.restart    = restart_q;
   assign playOut.sampleAddr = addr_q;
   assign running            = running_q;
   assign stopped            = stopped_q;
   assign trigEvent          = trig_q;

endmodule // wpt_trigger_ctrl

// file: wpt_trigger_ctrl_chk.sv
`timescale 1ns/1ps
module wpt_trigger_ctrl_chk (
   // Clock and reset
   input wire logic               clock,
   input wire logic               sys_rst,
   // Control and pin
   input wire wpt_pkg::wpt_cfg_t  cfg,
   input wire wpt_pkg::wpt_cmd_t  cmd,
   input wire logic               extTrigIn,
   // Outputs
   input wire wpt_pkg::wpt_play_t playOut,
   input wire logic               running,
   input wire logic               stopped,
   input wire logic               trigEvent
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire freeRun = cfg.mode == wpt_pkg::MODE_AUTO ||
                  cfg.mode == wpt_pkg::MODE_RETRIGGER;
   wire armed   = cfg.mode == wpt_pkg::MODE_ARMED_AUTO ||
                  cfg.mode == wpt_pkg::MODE_ARMED_RETRIG;
   property p_auto;
      (cfg.enable && cfg.mode == wpt_pkg::MODE_AUTO) [*4] |-> running;
   endproperty
   a_auto: assert property (p_auto) else $error("auto idle");
   property p_stop;
      stopped |-> !running && !playOut.play;
   endproperty
   a_stop: assert property (p_stop) else $error("status clash");
   property p_rstrt;
      playOut.restart |-> running && playOut.sampleAddr == wpt_pkg::LEN_ZERO;
   endproperty
   a_rstrt: assert property (p_rstrt) else $error("bad restart");
   property p_addr;
      running && $past(running) && !playOut.restart |->
         playOut.sampleAddr == $past(playOut.sampleAddr) + wpt_pkg::LEN_ONE
         || playOut.sampleAddr == wpt_pkg::LEN_ZERO;
   endproperty
   a_addr: assert property (p_addr) else $error("addr step");
   property p_retrig;
      cfg.enable && cfg.mode == wpt_pkg::MODE_RETRIGGER && trigEvent
         |-> playOut.restart;
   endproperty
   a_retrig: assert property (p_retrig) else $error("no restart");
   property p_arm;
      cfg.enable && armed && running && cmd.arm |=> !running && stopped;
   endproperty
   a_arm: assert property (p_arm) else $error("arm ignored");
   property p_start;
      cfg.enable && !freeRun && $rose(running) |-> trigEvent;
   endproperty
   a_start: assert property (p_start) else $error("early run");
   property p_man;
      !cfg.srcExternal && trigEvent |-> $past(cmd.manualTrig);
   endproperty
   a_man: assert property (p_man) else $error("stray event");
   c_single: cover property (cfg.mode == wpt_pkg::MODE_SINGLE
                             && $fell(running));
   c_ext: cover property (cfg.srcExternal && trigEvent);
   c_arm: cover property (armed && playOut.restart);
endmodule // wpt_trigger_ctrl_chk

bind wpt_trigger_ctrl wpt_trigger_ctrl_chk wpt_trigger_ctrl_chk_inst (
   .clock, .sys_rst, .cfg, .cmd, .extTrigIn,
   .playOut, .running, .stopped, .trigEvent
);

// file: wpt_ext_src.sv
`timescale 1ns/1ps
module wpt_ext_src (
   // Request and polarity
   input  wire logic fire,
   input  wire logic rising,
   // Trigger pin
   output logic      pin
);
   // Rests at the inactive level, so a polarity swap is never an event
   assign pin = fire ? rising : ~rising;
endmodule // wpt_ext_src

// file: wpt_tb.sv
`timescale 1ns/1ps
module testbench;
   logic               clock = 1'b0;
   logic               sys_rst = 1'b1;
   wpt_pkg::wpt_cfg_t  cfg;
   wpt_pkg::wpt_cmd_t  cmd;
   wpt_pkg::wpt_play_t playOut;
   logic               extTrigIn, running, stopped, trigEvent, act;
   logic [31:0]        rs = 32'h0000_D042;
   logic [31:0]        len = 32'h0;
   logic [31:0]        q[$];
   int                 errors = 0, n_compared = 0, cycles = 0;

   wpt_trigger_ctrl wpt_trigger_ctrl_inst (
      .clock, .sys_rst, .cfg, .cmd, .extTrigIn,
      .playOut, .running, .stopped, .trigEvent
   );
   wpt_ext_src wpt_ext_src_inst (
      .fire(act), .rising(cfg.extRising), .pin(extTrigIn)
   );

   initial begin
      forever #2.5 clock = ~clock;
   end

   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   task automatic cyc(int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One-cycle command: arm when a is set, manual trigger otherwise
   task automatic pulse(logic a);
      cmd = {a, ~a};
      cyc(1);
      cmd = 2'h0;
   endtask

   task automatic go(wpt_pkg::wpt_mode_t m);
      cfg.enable = 1'b0;
      cyc(3);
      cfg.mode = m;
      cyc(1);
      cfg.enable = 1'b1;
   endtask

   task test_done();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Measures each single-shot pass against the oldest note, sampling
   // at the falling edge where the outputs have settled
   always @(negedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         test_done();
      end
      if (running)
         len++;
      else if (len != 32'h0) begin
         if (cfg.mode == wpt_pkg::MODE_SINGLE)
            chk(len, q.pop_front());
         len = 32'h0;
      end
   end

   initial begin
      cfg = '0;
      cmd = 2'h0;
      act = 1'b0;
      cfg.waveLength = 24'h10;
      cyc(4);
      sys_rst = 1'b0;
      go(wpt_pkg::MODE_AUTO);
      cyc(20);
      chk(running, 1'b1);
      chk(playOut.play, 1'b1);
      chk(stopped, 1'b0);
      $display("free-run test done");
      go(wpt_pkg::MODE_RETRIGGER);
      cyc(6);
      pulse(1'b0);
      chk(playOut.sampleAddr, 24'h0);
      chk(playOut.restart, 1'b1);
      chk(trigEvent, 1'b1);
      cfg.srcExternal = 1'b1;
      cyc(4);
      pulse(1'b0);
      cyc(1);
      chk(playOut.sampleAddr == 24'h0, 1'b0);
      cfg.srcExternal = 1'b0;
      $display("retrigger test done");
      for (int i = 0; i < 2; i++) begin
         go(i ? wpt_pkg::MODE_ARMED_RETRIG : wpt_pkg::MODE_ARMED_AUTO);
         cyc(8);
         chk(stopped, 1'b1);
         pulse(1'b0);
         cyc(4);
         chk(running, 1'b1);
         pulse(1'b0);
         chk(playOut.sampleAddr == 24'h0, i);
         pulse(1'b1);
         cyc(1);
         chk(stopped, 1'b1);
         cyc(10);
         chk(running, 1'b0);
         pulse(1'b0);
         chk(playOut.sampleAddr, 24'h0);
         chk(playOut.restart, 1'b1);
         $display("armed test done");
      end
      go(wpt_pkg::MODE_SINGLE);
      for (int i = 0; i < 6; i++) begin
         cfg.durUnit = wpt_pkg::wpt_unit_t'(i[1]);
         cfg.duration = rnd() % 32'h8 + 32'h1;
         cfg.waveLength = 24'(rnd() % 32'h4 + 32'h1);
         cfg.srcExternal = i[0];
         cfg.extRising = ^rnd();
         q.push_back(i[1] ? cfg.duration * cfg.waveLength : cfg.duration);
         cyc(4);
         if (i[0]) begin
            act = 1'b1;
            cyc(3);
            act = 1'b0;
         end else
            pulse(1'b0);
         cyc(45);
         chk(stopped, 1'b1);
      end
      $display("single test done");
      test_done();
   end
endmodule // testbench
